// ===== hdl/desc_poll_timer.sv
// Descriptor poll timer: one tick every interval times the unit count while running.
// Assumes the interval it is given has already been floored to at least one.
`timescale 1ns/1ns
`default_nettype none
module desc_poll_timer
  import tx_dma_req_pkg::*;
#(
  parameter int UNIT_CYCLES = POLL_UNIT_CYCLES
) (
  // Clock and reset.
  input  wire logic    i_sys_clk,
  input  wire logic    i_reset,
  // Link to the controller.
  poll_link_if.timer   link
);
  typedef struct packed {
    poll_state_type state;
    logic [15:0]    cnt;
    logic           tick;
  } timer_state_type;

  timer_state_type st_r;
  timer_state_type st_nxt;
  logic [15:0]     reload;

  // The interval is re-read at every reload so a new value takes effect next period.
  assign reload    = 16'(32'(link.interval) * UNIT_CYCLES - 1);
  assign link.tick = st_r.tick;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    case (st_r.state)
      POLL_IDLE: begin
        if (link.run) begin
          st_nxt.state = POLL_COUNT;
          st_nxt.cnt   = reload;
        end
      end
      POLL_COUNT: begin
        if (!link.run) begin
          st_nxt.state = POLL_IDLE;
        end else if (st_r.cnt == 16'h0000) begin
          st_nxt.tick = 1'b1;
          st_nxt.cnt  = reload;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end
      default: begin
        st_nxt.state = POLL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '{state: POLL_IDLE, cnt: 16'h0000, tick: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : desc_poll_timer
`default_nettype wire

// ===== hdl/fetch_fifo.sv
// Synchronous FIFO between the host fetch side and the MAC side.
// Assumes both sides share the system clock; storage is flip-flops.
`timescale 1ns/1ns
`default_nettype none
module fetch_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  // Fill side.
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  // Drain side.
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fifo_state_type;

  fifo_state_type st_r;
  fifo_state_type st_nxt;
  logic           push;
  logic           pop;

  assign o_in_ready  = (st_r.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st_r.count != '0);
  assign o_out_data  = st_r.mem[st_r.rptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wptr] = i_in_data;
      st_nxt.wptr = st_r.wptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rptr = st_r.rptr + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : fetch_fifo
`default_nettype wire

// ===== hdl/poll_link_if.sv
// Carrier between the request controller and its descriptor poll timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface poll_link_if;
  logic [7:0] interval;
  logic       run;
  logic       tick;
  modport ctrl  (output interval, output run, input tick);
  modport timer (input interval, input run, output tick);
endinterface : poll_link_if
`default_nettype wire

// ===== hdl/tx_dma_req_pkg.sv
// Constants, types and helpers shared by the transmit DMA request control block.
// Assumes a single 100 MHz system clock and byte-addressed register offsets.
package tx_dma_req_pkg;

  // Register byte offsets.
  localparam logic [7:0]  POLL_INTERVAL_OFS  = 8'h1a;
  localparam logic [7:0]  FETCH_ROOM_OFS     = 8'h1c;
  localparam logic [7:0]  STARVE_LEVEL_OFS   = 8'h1d;
  localparam logic [7:0]  OVERSIZE_COUNT_OFS = 8'h1e;

  // Reset values.
  localparam logic [7:0]  POLL_INTERVAL_RST  = 8'hff;
  localparam logic [7:0]  FETCH_ROOM_RST     = 8'h08;
  localparam logic [7:0]  STARVE_LEVEL_RST   = 8'h04;
  localparam logic [15:0] OVERSIZE_COUNT_RST = 16'h0000;

  // Smallest values the hardware will act on.
  localparam logic [7:0]  FETCH_ROOM_MIN     = 8'h08;
  localparam logic [7:0]  STARVE_LEVEL_MIN   = 8'h04;
  localparam logic [7:0]  POLL_INTERVAL_MIN  = 8'h01;

  // Threshold units are 32 bytes, so a level is shifted left by this much.
  localparam int          LEVEL_UNIT_SHIFT   = 5;

  // Poll timing.
  localparam int          POLL_STEP_NS       = 320;
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          POLL_UNIT_CYCLES   = (POLL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Oversize frame limits and statistics marks.
  localparam logic [13:0] FRAME_MAX_PLAIN    = 14'd1518;
  localparam logic [13:0] FRAME_MAX_TAGGED   = 14'd1522;
  localparam logic [15:0] STATS_UPDATE_MARK  = 16'hc000;

  // Data path buffer.
  localparam int          FETCH_DATA_W       = 32;
  localparam int          FETCH_FIFO_DEPTH   = 16;

  typedef enum logic {POLL_IDLE, POLL_COUNT} poll_state_type;

  // Applies the floor on a programmed level.
  function automatic logic [7:0] floor_level(input logic [7:0] value, input logic [7:0] min_value);
    floor_level = (value < min_value) ? min_value : value;
  endfunction : floor_level

  // Converts a 32-byte-unit level to bytes.
  function automatic logic [13:0] level_bytes(input logic [7:0] value);
    level_bytes = {1'b0, value, 5'h00};
  endfunction : level_bytes

endpackage : tx_dma_req_pkg

// ===== hdl/tx_dma_request_control.sv
// Transmit DMA request control: request decisions, descriptor polling, oversize frame count.
// Assumes FIFO levels and frame reports are synchronous to i_sys_clk.
`timescale 1ns/1ns
`default_nettype none
module tx_dma_request_control
  import tx_dma_req_pkg::*;
#(
  parameter int POLL_UNIT = POLL_UNIT_CYCLES
) (
  // Clock and reset.
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_reset,
  // Register port.
  input  wire logic [7:0]              i_reg_addr,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  input  wire logic [15:0]             i_reg_wdata,
  output logic      [15:0]             o_reg_rdata,
  // Transmit DMA state and FIFO levels.
  input  wire logic                    i_tx_dma_active,
  input  wire logic [13:0]             i_txfifo_used_bytes,
  input  wire logic [13:0]             i_txfifo_free_bytes,
  input  wire logic [15:0]             i_fragment_length,
  input  wire logic                    i_rx_urgent_req,
  // Bus requests and polling.
  output logic                         o_tx_dma_req,
  output logic                         o_tx_urgent_req,
  output logic                         o_tx_arb_over_rx,
  output logic                         o_desc_poll_req,
  // Statistics.
  input  wire logic                    i_stats_enable,
  input  wire logic                    i_stats_mask_oversize,
  input  wire logic                    i_tx_frame_done,
  input  wire logic [13:0]             i_tx_frame_len,
  input  wire logic                    i_tx_frame_vlan,
  output logic                         o_stats_update,
  // Fetched data path.
  input  wire logic [FETCH_DATA_W-1:0] i_fetch_data,
  input  wire logic                    i_fetch_valid,
  output logic                         o_fetch_ready,
  output logic      [FETCH_DATA_W-1:0] o_mac_data,
  output logic                         o_mac_valid,
  input  wire logic                    i_mac_ready
);
  typedef struct packed {
    logic [7:0]  poll_interval;
    logic [7:0]  fetch_room;
    logic [7:0]  starve_level;
    logic [15:0] oversize_count;
    logic [15:0] rdata;
    logic        dma_req;
    logic        urgent_req;
    logic        stats_update;
  } ctrl_state_type;

  ctrl_state_type st_r;
  ctrl_state_type st_nxt;

  logic [13:0] room_bytes;
  logic [13:0] starve_bytes;
  logic [13:0] frame_limit;
  logic        count_frame;
  logic        wr_count;

  poll_link_if poll_link ();

  // Floors are applied on use, so software reads back exactly what it wrote.
  assign room_bytes   = level_bytes(floor_level(st_r.fetch_room, FETCH_ROOM_MIN));
  assign starve_bytes = level_bytes(floor_level(st_r.starve_level, STARVE_LEVEL_MIN));
  assign frame_limit  = i_tx_frame_vlan ? FRAME_MAX_TAGGED : FRAME_MAX_PLAIN;
  assign count_frame  = i_tx_frame_done && (i_tx_frame_len > frame_limit)
                        && i_stats_enable && !i_stats_mask_oversize;
  assign wr_count     = i_reg_wr && (i_reg_addr == OVERSIZE_COUNT_OFS);

  assign poll_link.interval = floor_level(st_r.poll_interval, POLL_INTERVAL_MIN);
  assign poll_link.run      = i_tx_dma_active;

  assign o_reg_rdata      = st_r.rdata;
  assign o_tx_dma_req     = st_r.dma_req;
  assign o_tx_urgent_req  = st_r.urgent_req;
  assign o_tx_arb_over_rx = st_r.urgent_req && !i_rx_urgent_req;
  assign o_desc_poll_req  = poll_link.tick;
  assign o_stats_update   = st_r.stats_update;

  always_comb begin
    st_nxt = st_r;
    st_nxt.stats_update = 1'b0;
    // Requests are held low whenever transmit DMA is idle.
    st_nxt.dma_req = i_tx_dma_active
                     && ((i_txfifo_free_bytes > room_bytes)
                         || ({2'b00, i_txfifo_used_bytes} > i_fragment_length));
    st_nxt.urgent_req = i_tx_dma_active && (i_txfifo_used_bytes < starve_bytes);
    if (i_reg_wr) begin
      case (i_reg_addr)
        POLL_INTERVAL_OFS:  st_nxt.poll_interval  = i_reg_wdata[7:0];
        FETCH_ROOM_OFS:     st_nxt.fetch_room     = i_reg_wdata[7:0];
        STARVE_LEVEL_OFS:   st_nxt.starve_level   = i_reg_wdata[7:0];
        OVERSIZE_COUNT_OFS: st_nxt.oversize_count = i_reg_wdata;
        default: begin
        end
      endcase
    end
    // A software write to the counter wins over a frame counted in the same cycle.
    if (count_frame && !wr_count) begin
      st_nxt.oversize_count = st_r.oversize_count + 16'h0001;
      st_nxt.stats_update   = (st_r.oversize_count + 16'h0001) == STATS_UPDATE_MARK;
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        POLL_INTERVAL_OFS:  st_nxt.rdata = {8'h00, st_r.poll_interval};
        FETCH_ROOM_OFS:     st_nxt.rdata = {8'h00, st_r.fetch_room};
        STARVE_LEVEL_OFS:   st_nxt.rdata = {8'h00, st_r.starve_level};
        OVERSIZE_COUNT_OFS: st_nxt.rdata = st_r.oversize_count;
        default:            st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '{poll_interval: POLL_INTERVAL_RST, fetch_room: FETCH_ROOM_RST,
                starve_level: STARVE_LEVEL_RST, oversize_count: OVERSIZE_COUNT_RST,
                rdata: 16'h0000, dma_req: 1'b0, urgent_req: 1'b0, stats_update: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  desc_poll_timer #(
    .UNIT_CYCLES (POLL_UNIT)
  ) u_poll_timer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .link      (poll_link.timer)
  );

  fetch_fifo #(
    .WIDTH (FETCH_DATA_W),
    .DEPTH (FETCH_FIFO_DEPTH)
  ) u_fetch_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_reset     (i_reset),
    .i_in_data   (i_fetch_data),
    .i_in_valid  (i_fetch_valid),
    .o_in_ready  (o_fetch_ready),
    .o_out_data  (o_mac_data),
    .o_out_valid (o_mac_valid),
    .i_out_ready (i_mac_ready)
  );

  // Helper logic that measures the spacing of poll ticks for the checks below.
  logic [15:0] gap_cnt;
  logic        gap_seen;
  logic [15:0] gap_expect;
  assign gap_expect = 16'(32'(floor_level(st_r.poll_interval, POLL_INTERVAL_MIN)) * POLL_UNIT);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      gap_cnt  <= 16'h0000;
      gap_seen <= 1'b0;
    end else if (!i_tx_dma_active || (i_reg_wr && (i_reg_addr == POLL_INTERVAL_OFS))) begin
      gap_cnt  <= 16'h0000;
      gap_seen <= 1'b0;
    end else if (o_desc_poll_req) begin
      gap_cnt  <= 16'h0001;
      gap_seen <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  property p_normal_req;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_tx_dma_active && (i_txfifo_free_bytes > room_bytes)) |=> o_tx_dma_req;
  endproperty
  a_normal_req: assert property (p_normal_req) else $error("normal request missing");

  property p_frag_override;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_tx_dma_active && ({2'b00, i_txfifo_used_bytes} > i_fragment_length)) |=> o_tx_dma_req;
  endproperty
  a_frag_override: assert property (p_frag_override) else $error("fragment override missing");

  property p_room_floor;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_tx_dma_active && (i_txfifo_free_bytes <= 14'd256)
       && ({2'b00, i_txfifo_used_bytes} <= i_fragment_length)) |=> !o_tx_dma_req;
  endproperty
  a_room_floor: assert property (p_room_floor) else $error("room level floor ignored");

  property p_poll_gap;
    @(posedge i_sys_clk) disable iff (i_reset)
      (o_desc_poll_req && gap_seen && i_tx_dma_active) |-> (gap_cnt == gap_expect);
  endproperty
  a_poll_gap: assert property (p_poll_gap) else $error("poll spacing wrong");

  property p_poll_alive;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_tx_dma_active |-> (gap_cnt <= gap_expect + 16'h0002);
  endproperty
  a_poll_alive: assert property (p_poll_alive) else $error("polling stalled");

  property p_urgent_req;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_tx_dma_active && (i_txfifo_used_bytes < starve_bytes)) |=> o_tx_urgent_req;
  endproperty
  a_urgent_req: assert property (p_urgent_req) else $error("urgent request missing");

  property p_arb;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_tx_arb_over_rx |-> (o_tx_urgent_req && !i_rx_urgent_req);
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration win without cause");

  property p_starve_floor;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_tx_dma_active && (i_txfifo_used_bytes < 14'd128)) |=> o_tx_urgent_req;
  endproperty
  a_starve_floor: assert property (p_starve_floor) else $error("starve level floor ignored");

  property p_count_inc;
    @(posedge i_sys_clk) disable iff (i_reset)
      (count_frame && !wr_count) |=> (st_r.oversize_count == $past(st_r.oversize_count) + 16'h0001);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("oversize frame not counted");

  property p_count_wrap;
    @(posedge i_sys_clk) disable iff (i_reset)
      (count_frame && !wr_count && (st_r.oversize_count == 16'hffff)) |=> (st_r.oversize_count == 16'h0000);
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("counter did not wrap");

  property p_update_mark;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_stats_update |-> ((st_r.oversize_count == STATS_UPDATE_MARK) && $past(count_frame));
  endproperty
  a_update_mark: assert property (p_update_mark) else $error("update pulse at wrong count");

  property p_count_gate;
    @(posedge i_sys_clk) disable iff (i_reset)
      (!wr_count && (!i_stats_enable || i_tx_frame_len <= frame_limit || !i_tx_frame_done))
      |=> $stable(st_r.oversize_count);
  endproperty
  a_count_gate: assert property (p_count_gate) else $error("counter moved without a counted frame");

  property p_mask_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_stats_mask_oversize && !wr_count) |=> $stable(st_r.oversize_count);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("masked counter moved");

  property p_no_req;
    @(posedge i_sys_clk) disable iff (i_reset)
      !i_tx_dma_active |=> (!o_tx_dma_req && !o_tx_urgent_req);
  endproperty
  a_no_req: assert property (p_no_req) else $error("request while idle");

  property p_normal_off;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_tx_dma_active && (i_txfifo_free_bytes <= room_bytes)
       && ({2'b00, i_txfifo_used_bytes} <= i_fragment_length)) |=> !o_tx_dma_req;
  endproperty
  a_normal_off: assert property (p_normal_off) else $error("normal request without cause");

  property p_urgent_off;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_txfifo_used_bytes >= starve_bytes) |=> !o_tx_urgent_req;
  endproperty
  a_urgent_off: assert property (p_urgent_off) else $error("urgent request without cause");

  property p_poll_idle;
    @(posedge i_sys_clk) disable iff (i_reset)
      !i_tx_dma_active |=> !o_desc_poll_req;
  endproperty
  a_poll_idle: assert property (p_poll_idle) else $error("poll while transmit idle");

  // Checked against the tagged limit itself, so a wrong limit select shows up here.
  property p_tagged_limit;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_tx_frame_done && i_tx_frame_vlan && (i_tx_frame_len <= FRAME_MAX_TAGGED) && !wr_count)
      |=> $stable(st_r.oversize_count);
  endproperty
  a_tagged_limit: assert property (p_tagged_limit) else $error("short tagged frame counted");

  property p_update_cause;
    @(posedge i_sys_clk) disable iff (i_reset)
      (count_frame && !wr_count && (st_r.oversize_count == STATS_UPDATE_MARK - 16'h0001)) |=> o_stats_update;
  endproperty
  a_update_cause: assert property (p_update_cause) else $error("update pulse missing at mark");

  property p_update_pulse;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_stats_update |=> !o_stats_update;
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("update pulse too long");

  c_urgent_win: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_tx_arb_over_rx);
  c_poll_twice: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_desc_poll_req && gap_seen);
  c_update:     cover property (@(posedge i_sys_clk) disable iff (i_reset) o_stats_update);
  c_fifo_full:  cover property (@(posedge i_sys_clk) disable iff (i_reset) i_fetch_valid && !o_fetch_ready);
  c_urgent_lost: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_tx_urgent_req && i_rx_urgent_req);
endmodule : tx_dma_request_control
`default_nettype wire

// ===== sim/host_mem_model.sv
// Host memory model: answers transmit fetch requests with counting data words.
// Assumes the controller's request and FIFO ready are synchronous to i_sys_clk.
`timescale 1ns/1ns
`default_nettype none
module host_mem_model
  import tx_dma_req_pkg::*;
(
  // Clock and reset.
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_reset,
  // Request side.
  input  wire logic                    i_req,
  input  wire logic                    i_slow,
  input  wire logic                    i_ready,
  // Data side.
  output logic      [FETCH_DATA_W-1:0] o_data,
  output logic                         o_valid,
  output logic      [7:0]              o_sent
);
  logic [1:0] gap_r;
  // A word stays offered until taken, even if the request drops meanwhile.
  // Idle data toggles so that a stale word can never pass for a fresh one.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_data  <= 32'h0;
      o_valid <= 1'b0;
      o_sent  <= 8'h00;
      gap_r   <= 2'h0;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_data  <= ~o_data;
      o_sent  <= o_sent + 8'h01;
      gap_r   <= i_slow ? 2'h2 : 2'h0;
    end else if (!o_valid && gap_r != 2'h0) begin
      gap_r  <= gap_r - 2'h1;
      o_data <= ~o_data;
    end else if (!o_valid && i_req) begin
      o_valid <= 1'b1;
      o_data  <= {24'ha5a500, o_sent};
    end else if (!o_valid) begin
      o_data <= ~o_data;
    end
  end
endmodule : host_mem_model
`default_nettype wire

// ===== sim/tx_dma_request_control_tb.sv
// Self-checking bench for the transmit DMA request control block.
// Assumes the host memory model on the fetch side and a shortened poll unit.
`timescale 1ns/1ns
`default_nettype none
module tx_dma_request_control_tb;
  import tx_dma_req_pkg::*;
  localparam int PU = 2;
  typedef struct packed {
    logic [7:0]  room;
    logic [7:0]  starve;
    logic [13:0] used;
    logic [13:0] free;
    logic [15:0] frag;
    logic        req;
    logic        urg;
  } vec_type;
  logic        i_sys_clk, i_reset, wr, rd, act, rxu, sen, smask, fdone, fvlan, slow, mrdy;
  logic [7:0]  addr, sent;
  logic [7:0]  out_cnt = 8'h00;
  logic [15:0] wdata, rdata, frag;
  logic [13:0] used, free, flen;
  logic        req, urg, arb, poll, supd, fval, frdy, mval, u;
  logic [31:0] fdat, mdat;
  int          error_cnt, checks, n;
  vec_type     vt [8] = '{
    '{8'h02, 8'h00, 14'd200, 14'd256, 16'hffff, 1'b0, 1'b0},
    '{8'h02, 8'h00, 14'd200, 14'd257, 16'hffff, 1'b1, 1'b0},
    '{8'h02, 8'h00, 14'd200, 14'd0, 16'h00c8, 1'b0, 1'b0},
    '{8'h02, 8'h00, 14'd201, 14'd0, 16'h00c8, 1'b1, 1'b0},
    '{8'h02, 8'h00, 14'd127, 14'd0, 16'hffff, 1'b0, 1'b1},
    '{8'h02, 8'h00, 14'd128, 14'd0, 16'hffff, 1'b0, 1'b0},
    '{8'hff, 8'hff, 14'd8159, 14'd8161, 16'hffff, 1'b1, 1'b1},
    '{8'hff, 8'hff, 14'd8160, 14'd8160, 16'hffff, 1'b0, 1'b0}
  };

  tx_dma_request_control #(.POLL_UNIT(PU)) dut (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_tx_dma_active(act), .i_txfifo_used_bytes(used), .i_txfifo_free_bytes(free),
    .i_fragment_length(frag), .i_rx_urgent_req(rxu),
    .o_tx_dma_req(req), .o_tx_urgent_req(urg), .o_tx_arb_over_rx(arb), .o_desc_poll_req(poll),
    .i_stats_enable(sen), .i_stats_mask_oversize(smask), .i_tx_frame_done(fdone),
    .i_tx_frame_len(flen), .i_tx_frame_vlan(fvlan), .o_stats_update(supd),
    .i_fetch_data(fdat), .i_fetch_valid(fval), .o_fetch_ready(frdy),
    .o_mac_data(mdat), .o_mac_valid(mval), .i_mac_ready(mrdy));

  host_mem_model host (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(req), .i_slow(slow), .i_ready(frdy),
    .o_data(fdat), .o_valid(fval), .o_sent(sent));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_sys_clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge i_sys_clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(negedge i_sys_clk);
    addr = a;
    rd   = 1'b1;
    @(negedge i_sys_clk);
    rd = 1'b0;
    chk(what, {16'h0, rdata}, {16'h0, exp});
  endtask : rd_reg

  // The update pulse is looked for over two cycles after the frame edge.
  task automatic frame(input logic [13:0] len, input logic v, output logic upd);
    @(negedge i_sys_clk);
    flen  = len;
    fvlan = v;
    fdone = 1'b1;
    @(negedge i_sys_clk);
    fdone = 1'b0;
    upd   = supd;
    @(negedge i_sys_clk);
    upd = upd | supd;
  endtask : frame

  task automatic poll_chk(input logic [7:0] v, input int per);
    int k;
    act = 1'b0;
    wr_reg(POLL_INTERVAL_OFS, {8'h00, v});
    act = 1'b1;
    k   = 0;
    while (poll !== 1'b1 && k < 1200) begin
      @(negedge i_sys_clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge i_sys_clk);
      k++;
    end while (poll !== 1'b1 && k < 1200);
    chk("poll period", k, per);
    act = 1'b0;
  endtask : poll_chk

  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // Every word leaving the FIFO must follow the host's order exactly.
  // Sampled just after the drive edge, so the values are those the next rising edge pops.
  always @(negedge i_sys_clk) begin
    #1;
    if (!i_reset && mval === 1'b1 && mrdy === 1'b1) begin
      chk("fifo word", mdat, {24'ha5a500, out_cnt});
      out_cnt = out_cnt + 8'h01;
    end
  end

  initial begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial begin
    {wr, rd, act, rxu, sen, smask, fdone, fvlan, slow} = '0;
    {addr, wdata, used, free, frag, flen} = '0;
    mrdy    = 1'b1;
    i_reset = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_reset = 1'b0;
    rd_reg(POLL_INTERVAL_OFS, 16'h00ff, "poll reset");
    rd_reg(FETCH_ROOM_OFS, {8'h00, FETCH_ROOM_RST}, "room reset");
    rd_reg(STARVE_LEVEL_OFS, {8'h00, STARVE_LEVEL_RST}, "starve reset");
    rd_reg(OVERSIZE_COUNT_OFS, OVERSIZE_COUNT_RST, "count reset");
    wr_reg(8'h1f, 16'h1234);
    rd_reg(8'h1f, 16'h0000, "unmapped");
    for (int i = 0; i < 8; i++) begin
      wr_reg(FETCH_ROOM_OFS, {8'h00, vt[i].room});
      wr_reg(STARVE_LEVEL_OFS, {8'h00, vt[i].starve});
      rd_reg(FETCH_ROOM_OFS, {8'h00, vt[i].room}, "room raw");
      {used, free, frag} = {vt[i].used, vt[i].free, vt[i].frag};
      rxu = i[1];
      act = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      chk("normal req", req, vt[i].req);
      chk("urgent req", urg, vt[i].urg);
      chk("arb over rx", arb, vt[i].urg & ~rxu);
    end
    {used, free, act} = {14'd0, 14'd8191, 1'b0};
    repeat (2) @(negedge i_sys_clk);
    chk("idle req", {req, urg}, 2'b00);
    poll_chk(8'h00, PU);
    poll_chk(8'h03, 3 * PU);
    poll_chk(8'hff, 255 * PU);
    n = 0;
    repeat (20) @(negedge i_sys_clk) n += (poll !== 1'b0);
    chk("poll when idle", n, 0);
    sen = 1'b1;
    frame(14'd1518, 1'b0, u);
    frame(14'd1519, 1'b0, u);
    frame(14'd1522, 1'b1, u);
    frame(14'd1523, 1'b1, u);
    rd_reg(OVERSIZE_COUNT_OFS, 16'h0002, "oversize count");
    smask = 1'b1;
    frame(14'd1600, 1'b0, u);
    rd_reg(OVERSIZE_COUNT_OFS, 16'h0002, "masked count");
    {smask, sen} = 2'b00;
    frame(14'd1600, 1'b0, u);
    rd_reg(OVERSIZE_COUNT_OFS, 16'h0002, "disabled count");
    sen = 1'b1;
    wr_reg(OVERSIZE_COUNT_OFS, 16'hbfff);
    frame(14'd2000, 1'b0, u);
    chk("update at mark", u, 1'b1);
    rd_reg(OVERSIZE_COUNT_OFS, 16'hc000, "count at mark");
    wr_reg(OVERSIZE_COUNT_OFS, 16'hffff);
    frame(14'd2000, 1'b1, u);
    chk("update on wrap", u, 1'b0);
    rd_reg(OVERSIZE_COUNT_OFS, 16'h0000, "count wrap");
    // The MAC side stalls while the slow host fills the buffer to refusal.
    {mrdy, slow, used, free, frag, act} = {1'b0, 1'b1, 14'd200, 14'd8191, 16'hffff, 1'b1};
    n = 0;
    while (frdy !== 1'b0 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("fetch ready at full", frdy, 1'b0);
    chk("fifo full level", 8'(sent - out_cnt), 8'd16);
    {act, slow, mrdy} = 3'b001;
    n = 0;
    while (mval !== 1'b0 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    repeat (4) @(negedge i_sys_clk);
    chk("fifo drained", {mval, 8'(sent - out_cnt)}, 9'h000);
    final_report();
  end
endmodule : tx_dma_request_control_tb
`default_nettype wire
